// *** rtl/sideband_controller.sv ***
// Controller end of the PHY sideband: in-band symbol stream and management bus master.
// Assumes symbol streams are on CLK; bus pins are open drain with board pull-ups.
//
// Behaviour
// - Packet: K28.1, header, two data, zero, CRC
// - CRC covers header, data, reserved, not K28.1
// - Acknowledge header is 0xC0
// - Ack byte one: bits 7:6,3 zero
// - Ack byte one bit 4: receive idle state
// - Ack byte two carries link flags
// - Speed code 11b never sent
// - Controller status header is 0x80
// - Status byte one: bits 7:4 reserved
// - Status byte two: reset, power, state, LED
// - Management bus carries same traffic in sleep
// - Bus lines only pulled low or released
// - Bus speed 100, 400 or 1000 kHz
//
// The address map and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module sideband_controller #(
    parameter int T_TIMEOUT = sideband_pkg::TIMEOUT_CYC,
    parameter int T_HANG = sideband_pkg::HANG_CYC
) (
    input wire logic CLK,
    input wire logic SRST,
    input wire logic [7:0] ADDR,
    input wire logic [31:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [31:0] RDATA,
    output var sideband_pkg::sym_t TX_SYM,
    input wire logic TX_READY,
    input wire sideband_pkg::sym_t RX_SYM,
    input wire logic SCL_IN,
    output logic SCL_OUT,
    output logic SCL_OE,
    input wire logic SDA_IN,
    output logic SDA_OUT,
    output logic SDA_OE
);
    import sideband_pkg::*;

    default clocking @(posedge CLK); endclocking
    default disable iff (SRST);

    function automatic logic [7:0] pick(input pkt_t p, input logic [7:0] c,
                                        input logic [2:0] i, input logic [7:0] first);
        case (i)
            3'd0: pick = first;
            3'd1: pick = p.hdr;
            3'd2: pick = p.d1;
            3'd3: pick = p.d2;
            3'd4: pick = p.rsv;
            default: pick = c;
        endcase
    endfunction : pick

    logic [7:0] st_d1, st_d2, ack_d1, ack_d2;
    logic bus_sel;
    logic [1:0] speed;
    logic ack_pending, status_pending, await_ack;
    logic status_new, ack_seen, mgmt_nack, mgmt_fault;
    logic [15:0] phy_status;
    pkt_t job_pkt;
    logic job_is_ack, job_busy, job_on_bus;
    logic [2:0] tx_idx, out_idx;
    logic out_ack;
    logic [2:0] rx_cnt;
    pkt_t rx_pkt;
    logic [7:0] rx_crc, rx_crc_next;
    mst_t mst;
    logic [1:0] phase;
    logic [2:0] byte_i;
    logic [3:0] bit_i;
    logic scl_low, sda_low, nack;
    logic [7:0] qtr_cnt;
    logic [21:0] stretch_cnt, low_cnt;
    logic scl_m, scl_s, sda_m, sda_s;

    ////////////////////////////////////////////////////////////////////////////////
    // Register decode
    wire wr_ctrl = WR && (ADDR == REG_CTRL);
    wire wr_tx = WR && (ADDR == REG_TX_DATA);
    wire wr_ack = WR && (ADDR == REG_ACK_DATA);
    wire rd_status = RD && (ADDR == REG_STATUS);
    wire [1:0] wr_speed = WDATA[CTRL_SPD_LSB +: 2];
    wire start_job = !job_busy && (ack_pending || status_pending);
    wire [31:0] status_word = {10'h000, await_ack, mgmt_fault, mgmt_nack, job_busy,
                               ack_seen, status_new, phy_status};
    wire [31:0] rd_mux = (ADDR == REG_CTRL) ? {28'h0000_000, speed, bus_sel, 1'b0} :
                         (ADDR == REG_TX_DATA) ? {16'h0000, st_d2, st_d1} :
                         (ADDR == REG_ACK_DATA) ? {16'h0000, ack_d2, ack_d1} :
                         (ADDR == REG_STATUS) ? status_word : 32'h0000_0000;

    // Software settings; reserved fields are masked so they can never go out
    always_ff @(posedge CLK) begin
        if (SRST) begin
            bus_sel <= 1'b0;
            speed <= SPD_100K;
            st_d1 <= ZERO_BYTE;
            st_d2 <= ZERO_BYTE;
            ack_d1 <= ZERO_BYTE;
            ack_d2 <= ZERO_BYTE;
        end else begin
            if (wr_ctrl) begin
                bus_sel <= WDATA[CTRL_BUS];
                if (wr_speed != SPEED_RSVD) speed <= wr_speed;
            end
            if (wr_tx) begin
                st_d1 <= WDATA[7:0] & STAT_D1_MASK;
                st_d2 <= WDATA[15:8];
            end
            if (wr_ack) begin
                ack_d1 <= WDATA[7:0] & ACK_D1_MASK;
                ack_d2[7:2] <= WDATA[15:10];
                if (WDATA[9:8] != SPEED_RSVD) ack_d2[1:0] <= WDATA[9:8];
            end
        end
    end

    // Read data stand only in the cycle after the strobe
    always_ff @(posedge CLK) begin
        if (SRST) RDATA <= 32'h0000_0000;
        else RDATA <= RD ? rd_mux : 32'h0000_0000;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Receive path: a K28.1 always resynchronises, so a torn packet cannot stick
    wire rx_go = RX_SYM.valid && RX_SYM.k && (RX_SYM.data == SYM_K28_1);
    wire rx_end = RX_SYM.valid && !RX_SYM.k && (rx_cnt == LAST_IDX);
    wire rx_good = rx_end && (RX_SYM.data == rx_crc) && (rx_pkt.rsv == ZERO_BYTE);
    wire rx_status = rx_good && (rx_pkt.hdr == HDR_STATUS) &&
                     ((rx_pkt.d1 & PHY_D1_RSVD) == ZERO_BYTE);
    wire rx_ack = rx_good && (rx_pkt.hdr == HDR_ACK) &&
                  (rx_pkt.d1 == ZERO_BYTE) && (rx_pkt.d2 == ZERO_BYTE);

    crc8_step u_rx_crc (
        .crc_in(rx_crc),
        .data(RX_SYM.data),
        .crc_out(rx_crc_next)
    );

    // Bytes shift in so the header lands in the top field
    always_ff @(posedge CLK) begin
        if (SRST) begin
            rx_cnt <= 3'd0;
            rx_crc <= CRC_INIT;
            rx_pkt <= '0;
        end else if (rx_go) begin
            rx_cnt <= 3'd1;
            rx_crc <= CRC_INIT;
        end else if (RX_SYM.valid) begin
            if (RX_SYM.k || rx_cnt == 3'd0 || rx_cnt == LAST_IDX) begin
                rx_cnt <= 3'd0;
            end else begin
                rx_pkt <= {rx_pkt[23:0], RX_SYM.data};
                rx_crc <= rx_crc_next;
                rx_cnt <= rx_cnt + 3'd1;
            end
        end
    end

    // Sticky flags: a new event wins over a read that clears it
    always_ff @(posedge CLK) begin
        if (SRST) begin
            phy_status <= 16'h0000;
            status_new <= 1'b0;
            ack_seen <= 1'b0;
            ack_pending <= 1'b0;
            status_pending <= 1'b0;
            await_ack <= 1'b0;
        end else begin
            if (rx_status) phy_status <= {rx_pkt.d2, rx_pkt.d1};
            status_new <= rx_status || (status_new && !rd_status);
            ack_seen <= rx_ack || (ack_seen && !rd_status);
            ack_pending <= rx_status || (ack_pending && !(start_job && ack_pending));
            status_pending <= (wr_ctrl && WDATA[CTRL_SEND]) ||
                              (status_pending && !(start_job && !ack_pending));
            await_ack <= (start_job && !ack_pending) || (await_ack && !rx_ack);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Job latch: answering the PHY goes ahead of our own status
    pkt_t next_job;
    assign next_job = ack_pending ? pkt_t'{HDR_ACK, ack_d1, ack_d2, ZERO_BYTE}
                                  : pkt_t'{HDR_STATUS, st_d1, st_d2, ZERO_BYTE};
    logic [7:0] chain [0:4];
    assign chain[0] = CRC_INIT;
    for (genvar g = 0; g < 4; g++) begin : g_tx_crc
        crc8_step u_tx_crc (
            .crc_in(chain[g]),
            .data(job_pkt[31 - 8 * g -: 8]),
            .crc_out(chain[g + 1])
        );
    end
    wire [7:0] crc_tx = chain[4];
    wire tx_load = job_busy && !job_on_bus && (!TX_SYM.valid || TX_READY);
    wire [7:0] tx_byte = pick(job_pkt, crc_tx, tx_idx, SYM_K28_1);
    wire tick = (mst != M_IDLE) && (qtr_cnt == 8'h00);
    wire bus_end = tick && (mst == M_STOP) && (phase == 2'd3);
    wire hang_trip = (low_cnt > 22'(T_HANG)) && (scl_low || sda_low);
    wire timeout_trip = stretch_cnt >= 22'(T_TIMEOUT);

    always_ff @(posedge CLK) begin
        if (SRST) begin
            job_busy <= 1'b0;
            job_on_bus <= 1'b0;
            job_is_ack <= 1'b0;
            job_pkt <= '0;
        end else if (start_job) begin
            job_busy <= 1'b1;
            job_on_bus <= bus_sel;
            job_is_ack <= ack_pending;
            job_pkt <= next_job;
        end else if ((tx_load && tx_idx == LAST_IDX) || bus_end ||
                     (hang_trip && mst != M_IDLE)) begin
            job_busy <= 1'b0;
        end
    end

    // Symbol output register; each symbol stands until TX_READY takes it
    always_ff @(posedge CLK) begin
        if (SRST) begin
            TX_SYM <= '0;
            tx_idx <= 3'd0;
            out_idx <= 3'd0;
            out_ack <= 1'b0;
        end else begin
            if (start_job) tx_idx <= 3'd0;
            if (tx_load) begin
                TX_SYM <= sym_t'{1'b1, (tx_idx == 3'd0), tx_byte};
                out_idx <= tx_idx;
                out_ack <= job_is_ack;
                tx_idx <= tx_idx + 3'd1;
            end else if (TX_READY) begin
                TX_SYM.valid <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Management bus master: quarter-bit divider, synchronised pins
    wire [7:0] qtr_len = (speed == SPD_1000K) ? 8'(QTR_1000K - 1) :
                         (speed == SPD_400K) ? 8'(QTR_400K - 1) : 8'(QTR_100K - 1);
    wire [7:0] bus_byte = (byte_i == 3'd0) ? MGMT_ADDR_WR :
                          pick(job_pkt, crc_tx, byte_i, ZERO_BYTE);
    wire bus_bit = bus_byte[3'd7 - bit_i[2:0]];
    wire bus_go = start_job && bus_sel;

    always_ff @(posedge CLK) begin
        if (SRST) begin
            scl_m <= 1'b1;
            scl_s <= 1'b1;
            sda_m <= 1'b1;
            sda_s <= 1'b1;
            qtr_cnt <= 8'h00;
        end else begin
            scl_m <= SCL_IN;
            scl_s <= scl_m;
            sda_m <= SDA_IN;
            sda_s <= sda_m;
            qtr_cnt <= (mst == M_IDLE || qtr_cnt == 8'h00) ? qtr_len : qtr_cnt - 8'h01;
        end
    end

    // Watchdogs: stretch while we release the clock, any line held low
    always_ff @(posedge CLK) begin
        if (SRST) begin
            stretch_cnt <= 22'h00_0000;
            low_cnt <= 22'h00_0000;
        end else begin
            if (mst != M_IDLE && !scl_low && !scl_s && !timeout_trip)
                stretch_cnt <= stretch_cnt + 22'h00_0001;
            else if (scl_s || mst == M_IDLE)
                stretch_cnt <= 22'h00_0000;
            if (scl_s && sda_s) low_cnt <= 22'h00_0000;
            else if (low_cnt != 22'h3F_FFFF) low_cnt <= low_cnt + 22'h00_0001;
        end
    end

    // Bit engine: phase 0 data, 1 clock up, 2 wait high and sample, 3 clock down
    always_ff @(posedge CLK) begin
        if (SRST) begin
            mst <= M_IDLE;
            phase <= 2'd0;
            byte_i <= 3'd0;
            bit_i <= 4'd0;
            scl_low <= 1'b0;
            sda_low <= 1'b0;
            nack <= 1'b0;
        end else if (hang_trip) begin
            mst <= M_IDLE;
            scl_low <= 1'b0;
            sda_low <= 1'b0;
        end else if ((mst == M_START || mst == M_BITS) && timeout_trip) begin
            mst <= M_STOP;
            phase <= 2'd0;
        end else if (mst == M_IDLE) begin
            if (bus_go) begin
                mst <= M_START;
                phase <= 2'd0;
                byte_i <= 3'd0;
                bit_i <= 4'd0;
                nack <= 1'b0;
            end
        end else if (tick) begin
            unique case (mst)
                M_IDLE: ;
                M_START: begin
                    if (phase == 2'd0) phase <= 2'd1;
                    else if (phase == 2'd1 && scl_s && sda_s) begin
                        sda_low <= 1'b1;
                        phase <= 2'd2;
                    end else if (phase == 2'd2) begin
                        scl_low <= 1'b1;
                        mst <= M_BITS;
                        phase <= 2'd0;
                    end
                end
                M_BITS: begin
                    if (phase == 2'd0) begin
                        sda_low <= (bit_i == 4'd8) ? 1'b0 : !bus_bit;
                        phase <= 2'd1;
                    end else if (phase == 2'd1) begin
                        scl_low <= 1'b0;
                        phase <= 2'd2;
                    end else if (phase == 2'd2) begin
                        if (scl_s) begin
                            if (bit_i == 4'd8 && sda_s) nack <= 1'b1;
                            phase <= 2'd3;
                        end
                    end else begin
                        scl_low <= 1'b1;
                        phase <= 2'd0;
                        if (bit_i != 4'd8) bit_i <= bit_i + 4'd1;
                        else if (nack || byte_i == LAST_IDX) mst <= M_STOP;
                        else begin
                            bit_i <= 4'd0;
                            byte_i <= byte_i + 3'd1;
                        end
                    end
                end
                M_STOP: begin
                    if (phase == 2'd0) begin
                        scl_low <= 1'b1;
                        sda_low <= 1'b1;
                        phase <= 2'd1;
                    end else if (phase == 2'd1) begin
                        scl_low <= 1'b0;
                        phase <= 2'd2;
                    end else if (phase == 2'd2) begin
                        if (scl_s) phase <= 2'd3;
                    end else begin
                        sda_low <= 1'b0;
                        mst <= M_IDLE;
                    end
                end
            endcase
        end
    end

    // Error flags, cleared by reading the status word; a new error wins
    always_ff @(posedge CLK) begin
        if (SRST) begin
            mgmt_nack <= 1'b0;
            mgmt_fault <= 1'b0;
        end else begin
            mgmt_nack <= bus_end && nack || (mgmt_nack && !rd_status);
            mgmt_fault <= (hang_trip || (timeout_trip && mst != M_IDLE)) ||
                          (mgmt_fault && !rd_status);
        end
    end

    // Open drain: only ever drive low
    assign SCL_OUT = 1'b0;
    assign SDA_OUT = 1'b0;
    assign SCL_OE = scl_low;
    assign SDA_OE = sda_low;

    ////////////////////////////////////////////////////////////////////////////////
    a_sym_k_first:
    assert property (TX_SYM.valid && out_idx == 3'd0 |-> TX_SYM.k && TX_SYM.data == SYM_K28_1)
        else $error("first symbol is not K28.1");
    a_crc_tail:
    assert property (tx_load && tx_idx == LAST_IDX |=> TX_SYM.data == crc_tx && !TX_SYM.k)
        else $error("trailing CRC wrong");
    a_ack_header:
    assert property (TX_SYM.valid && out_ack && out_idx == 3'd1 |-> TX_SYM.data == HDR_ACK)
        else $error("ack header wrong");
    a_ack_d1_resv:
    assert property (TX_SYM.valid && out_ack && out_idx == 3'd2 |-> !TX_SYM.data[7] &&
                     !TX_SYM.data[6] && !TX_SYM.data[3])
        else $error("ack first data reserved bits set");
    a_speed_legal:
    assert property (TX_SYM.valid && out_ack && out_idx == 3'd3 |-> TX_SYM.data[1:0] != SPEED_RSVD)
        else $error("reserved speed code sent");
    a_status_hdr:
    assert property (TX_SYM.valid && !out_ack && out_idx == 3'd1 |-> TX_SYM.data == HDR_STATUS)
        else $error("status header wrong");
    a_status_d1:
    assert property (TX_SYM.valid && !out_ack && out_idx == 3'd2 |-> TX_SYM.data[7:4] == 4'h0)
        else $error("status reserved bits set");
    a_rsv_zero:
    assert property (TX_SYM.valid && out_idx == 3'd4 |-> TX_SYM.data == ZERO_BYTE)
        else $error("reserved byte not zero");
    a_bad_pkt_drop:
    assert property (rx_end && !rx_good && !ack_pending |=> !ack_pending [*2])
        else $error("bad packet was answered");
    a_open_drain:
    assert property (!SCL_OUT && !SDA_OUT)
        else $error("bus line driven high");
    a_hang_release:
    assert property (hang_trip |=> !SCL_OE && !SDA_OE && mst == M_IDLE)
        else $error("hung bus not released");
    a_timeout_stop:
    assert property (timeout_trip && mst == M_BITS && !hang_trip |=> mst == M_STOP)
        else $error("timeout did not lead to STOP");
endmodule : sideband_controller
`default_nettype wire

// *** inc/sideband_pkg.sv ***
// Shared constants and types for the sideband controller.
// Assumes a 100 MHz core clock and an 8-bit register address.
package sideband_pkg;
    localparam int CLK_HZ = 100_000_000;
    // In-band packet symbols and headers
    localparam logic [7:0] SYM_K28_1 = 8'h3C;
    localparam logic [7:0] HDR_STATUS = 8'h80;
    localparam logic [7:0] HDR_ACK = 8'hC0;
    localparam logic [7:0] ACK_D1_MASK = 8'h37;
    localparam logic [7:0] STAT_D1_MASK = 8'h0F;
    localparam logic [7:0] PHY_D1_RSVD = 8'hC8;
    localparam logic [1:0] SPEED_RSVD = 2'b11;
    localparam logic [7:0] CRC_POLY = 8'h07;
    localparam logic [7:0] CRC_INIT = 8'h00;
    localparam logic [7:0] ZERO_BYTE = 8'h00;
    localparam logic [2:0] LAST_IDX = 3'd5;
    // Management bus
    localparam logic [7:0] MGMT_ADDR_WR = 8'hC8;
    localparam logic [1:0] SPD_100K = 2'b00;
    localparam logic [1:0] SPD_400K = 2'b01;
    localparam logic [1:0] SPD_1000K = 2'b10;
    localparam int F_100K = 100_000;
    localparam int F_400K = 400_000;
    localparam int F_1000K = 1_000_000;
    localparam int QTR_100K = (CLK_HZ + 4 * F_100K - 1) / (4 * F_100K);
    localparam int QTR_400K = (CLK_HZ + 4 * F_400K - 1) / (4 * F_400K);
    localparam int QTR_1000K = (CLK_HZ + 4 * F_1000K - 1) / (4 * F_1000K);
    localparam int TIMEOUT_MS = 25;
    localparam int HANG_MS = 35;
    localparam int TIMEOUT_CYC = (CLK_HZ / 1000) * TIMEOUT_MS;
    localparam int HANG_CYC = (CLK_HZ / 1000) * HANG_MS;
    // Register map
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_TX_DATA = 8'h04;
    localparam logic [7:0] REG_ACK_DATA = 8'h08;
    localparam logic [7:0] REG_STATUS = 8'h0C;
    localparam int CTRL_SEND = 0;
    localparam int CTRL_BUS = 1;
    localparam int CTRL_SPD_LSB = 2;

    typedef struct packed {
        logic [7:0] hdr;
        logic [7:0] d1;
        logic [7:0] d2;
        logic [7:0] rsv;
    } pkt_t;

    typedef struct packed {
        logic valid;
        logic k;
        logic [7:0] data;
    } sym_t;

    typedef enum logic [1:0] {
        M_IDLE = 2'b00,
        M_START = 2'b01,
        M_BITS = 2'b10,
        M_STOP = 2'b11
    } mst_t;
endpackage : sideband_pkg

// *** rtl/crc8_step.sv ***
// One byte step of the CRC-8 used on in-band packets.
// Purely combinational; the caller holds the running value.
`timescale 1ns/1ps
`default_nettype none
module crc8_step (
    input wire logic [7:0] crc_in,
    input wire logic [7:0] data,
    output logic [7:0] crc_out
);
    import sideband_pkg::*;

    // MSB first shift through x^8+x^2+x+1
    always_comb begin
        logic [7:0] c;
        c = crc_in ^ data;
        for (int i = 0; i < 8; i++) begin
            c = c[7] ? ({c[6:0], 1'b0} ^ CRC_POLY) : {c[6:0], 1'b0};
        end
        crc_out = c;
    end
endmodule : crc8_step
`default_nettype wire

// *** testbench/phy_model.sv ***
// PHY end of the sideband: acks controller status, sends status on demand.
// Assumes same-clock symbol streams; the bench resolves the open-drain clock.
`timescale 1ns/1ps
`default_nettype none
module phy_model (
    input wire logic clk,
    input wire sideband_pkg::sym_t tx_sym,
    output logic tx_ready,
    output var sideband_pkg::sym_t rx_sym,
    input wire logic scl,
    output logic scl_oe
);
    import sideband_pkg::*;
    logic stretch = 1'b0;
    logic [2:0] idx = 3'd0;
    logic [7:0] hdr = 8'h00;
    initial begin
        rx_sym = '0;
        tx_ready = 1'b0;
        scl_oe = 1'b0;
    end
    ////////////////////////////////////////
    // Bitwise CRC, MSB first; the K symbol is never fed in
    function automatic logic [7:0] crc8(input logic [31:0] b);
        logic [7:0] c;
        c = CRC_INIT;
        for (int i = 31; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ b[i]) ? CRC_POLY : 8'h00);
        return c;
    endfunction : crc8
    // Idle cycles carry junk so a stale byte never passes for data
    task automatic send(input logic [31:0] b, input logic bad);
        logic [7:0] s [6];
        s = '{SYM_K28_1, b[31:24], b[23:16], b[15:8], b[7:0], crc8(b) ^ {7'd0, bad}};
        for (int i = 0; i < 6; i++) begin
            rx_sym <= '{valid: 1'b1, k: (i == 0), data: s[i]};
            @(posedge clk);
        end
        rx_sym <= '{valid: 1'b0, k: 1'b0, data: 8'($urandom)};
    endtask : send
    // Random sink stalls; once stretching, the clock is held low after it falls
    always @(posedge clk) begin
        tx_ready <= 1'($urandom);
        scl_oe <= stretch & (scl_oe | !scl);
        if (tx_sym.valid && tx_ready) begin
            idx <= tx_sym.k ? 3'd1 : idx + 3'd1;
            if (idx == 3'd1) hdr <= tx_sym.data;
            if (idx == 3'd5 && hdr == HDR_STATUS) fork send({HDR_ACK, 24'h0}, 1'b0); join_none
        end
    end
endmodule : phy_model
`default_nettype wire

// *** testbench/tb_sideband_controller.sv ***
// Self-checking bench for the sideband controller: registers, symbol link, bus.
// Assumes phy_model on the far side and pull-ups on both bus lines.
`timescale 1ns/1ps
`default_nettype none
module tb_sideband_controller;
    import sideband_pkg::*;
    logic CLK = 1'b0;
    logic SRST = 1'b1;
    logic WR = 1'b0;
    logic RD = 1'b0;
    logic [7:0] ADDR = 8'h00;
    logic [31:0] WDATA = 32'h0000_0000;
    logic [31:0] RDATA, rd, v, s, a;
    logic SCL_OUT, SCL_OE, SDA_OUT, SDA_OE, ph_oe, TX_READY;
    logic scl_q = 1'b1;
    logic [7:0] abyte = 8'h00;
    logic sda_q = 1'b1;
    sym_t TX_SYM, RX_SYM;
    logic [8:0] txq [$];
    int num_errors = 0;
    int n_checks = 0;
    int per = 0;
    int cnt = 0;
    int nr = 0;
    int qtr [3] = '{QTR_100K, QTR_400K, QTR_1000K};
    // Open drain: low while any party pulls, else high through the pull-up
    wire SCL_IN = !(SCL_OE || ph_oe);
    wire SDA_IN = !SDA_OE;
    wire rise = SCL_IN && !scl_q;
    // Hang limit must exceed the longest legal low run: 14 quarters at 100 kHz
    sideband_controller #(.T_TIMEOUT(2000), .T_HANG(4000)) dut_u (
        .CLK(CLK), .SRST(SRST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
        .RDATA(RDATA), .TX_SYM(TX_SYM), .TX_READY(TX_READY), .RX_SYM(RX_SYM),
        .SCL_IN(SCL_IN), .SCL_OUT(SCL_OUT), .SCL_OE(SCL_OE), .SDA_IN(SDA_IN),
        .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE));
    phy_model phy_u (.clk(CLK), .tx_sym(TX_SYM), .tx_ready(TX_READY), .rx_sym(RX_SYM),
        .scl(SCL_IN), .scl_oe(ph_oe));
    initial forever #5 CLK = ~CLK;
    ////////////////////////////////////////
    // Log accepted symbols; time rises two and three after a START, shift in address
    always @(posedge CLK) begin
        if (TX_SYM.valid && TX_READY) txq.push_back({TX_SYM.k, TX_SYM.data});
        scl_q <= SCL_IN;
        sda_q <= SDA_IN;
        cnt <= rise ? 0 : cnt + 1;
        nr <= (SCL_IN && sda_q && !SDA_IN) ? 0 : nr + int'(rise);
        if (rise && nr == 2) per <= cnt + 1;
        if (rise && nr < 8) abyte <= {abyte[6:0], SDA_IN};
    end
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic end_of_test();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : end_of_test
    // Bus cycles end with a spare edge so a strobe is never set twice in one step
    task automatic wr(input logic [7:0] ad, input logic [31:0] d);
        WR <= 1'b1;
        ADDR <= ad;
        WDATA <= d;
        @(posedge CLK);
        WR <= 1'b0;
        @(posedge CLK);
    endtask : wr
    task automatic rdreg(input logic [7:0] ad);
        RD <= 1'b1;
        ADDR <= ad;
        @(posedge CLK);
        RD <= 1'b0;
        #1 rd = RDATA;
        @(posedge CLK);
    endtask : rdreg
    // Reads clear stickies, so the read that shows the bit is the one kept
    task automatic wait_st(input int n, input int b);
        for (int k = 0; k <= n; k++) begin
            rdreg(REG_STATUS);
            if (rd[b] === 1'b1) return;
        end
        check("status wait", 32'(b), 32'hFFFF_FFFF);
        end_of_test();
    endtask : wait_st
    task automatic chk_pkt(input logic [31:0] b);
        for (int k = 0; k < 400 && txq.size() < 6; k++) @(posedge CLK);
        if (txq.size() < 6) begin
            check("packet length", 32'(txq.size()), 32'd6);
            end_of_test();
        end
        check("lead symbol", 32'(txq.pop_front()), {23'd0, 1'b1, SYM_K28_1});
        for (int k = 3; k >= 0; k--) check("body", 32'(txq.pop_front()), 32'(b[8*k+:8]));
        check("crc", 32'(txq.pop_front()), 32'(phy_u.crc8(b)));
    endtask : chk_pkt
    ////////////////////////////////////////
    initial begin
        void'($urandom(32'h3883));
        repeat (8) @(posedge CLK);
        SRST <= 1'b0;
        @(posedge CLK);
        rdreg(REG_STATUS);
        check("status at reset", rd, 32'h0000_0000);
        rdreg(8'h10);
        check("unmapped", rd, 32'h0000_0000);
        // Controller status; the first has every reserved bit set
        for (int i = 0; i < 5; i++) begin
            v = (i == 0) ? 32'h0000_FFFF : $urandom;
            wr(REG_TX_DATA, v);
            wr(REG_CTRL, 32'h0000_0001);
            chk_pkt({HDR_STATUS, v[7:0] & STAT_D1_MASK, v[15:8], ZERO_BYTE});
            wait_st(50, 17);
        end
        // PHY status at each speed code, then a refused 11b that keeps the old code
        for (int i = 0; i < 4; i++) begin
            if (i < 3) begin
                a = $urandom;
                a[9:8] = 2'(i);
            end
            wr(REG_ACK_DATA, (i < 3) ? a : a | 32'h0000_0300);
            s = $urandom & 32'h0000_FF37;
            phy_u.send({HDR_STATUS, s[7:0], s[15:8], ZERO_BYTE}, 1'b0);
            chk_pkt({HDR_ACK, a[7:0] & ACK_D1_MASK, a[15:8], ZERO_BYTE});
            rdreg(REG_STATUS);
            check("phy status", 32'(rd[16:0]), {15'd0, 1'b1, s[15:0]});
        end
        // Bad CRC, then a nonzero reserved byte: neither is acked
        for (int i = 0; i < 2; i++) begin
            phy_u.send({HDR_STATUS, 16'h0001, 7'd0, 1'(i)}, i == 0);
            repeat (30) @(posedge CLK);
            check("no ack", 32'(txq.size()), 32'd0);
            rdreg(REG_STATUS);
            check("no status", 32'(rd[16]), 32'd0);
        end
        // Bus write at each speed with nobody answering the address
        for (int i = 0; i < 3; i++) begin
            wr(REG_CTRL, 32'(4 * i + 3));
            wait_st(6000, 19);
            check("bus address", 32'(abyte), 32'(MGMT_ADDR_WR));
            check("bit period", 32'(per), 32'(4 * qtr[i]));
        end
        // Far side holds the clock low: abort, then our own pulls are dropped
        phy_u.stretch <= 1'b1;
        wr(REG_CTRL, 32'h0000_000B);
        wait_st(3000, 20);
        repeat (3100) @(posedge CLK);
        check("lines released", 32'({SCL_OE, SDA_OE}), 32'd0);
        phy_u.stretch <= 1'b0;
        repeat (200) @(posedge CLK);
        rdreg(REG_STATUS);
        check("job ended", 32'(rd[18]), 32'd0);
        end_of_test();
    end
endmodule : tb_sideband_controller
`default_nettype wire
